// ---- hdl/rssi_top.sv ----
// System indicator and fault relay logic of the repeater, with its register file.
//
// Operation
// - Rate detected and supply healthy: steady green, relay closed.
// - Once rate detected, it stays detected until power is removed.
// - Rate undetected: flash red, relay stays closed.
// - No sending partner or invalid rate keeps rate undetected.
// - Token frames alone never complete rate detection.
// - A second active station's frame completes detection, ending red flashing.
// - Rate known but slot time undetermined: alternate red and green.
// - Ring mode on only one optical channel: alternate red and green.
// - Slot time too short: alternate red and green, relay closed.
// - Supply failure, miswiring or internal defect: indicator dark, relay open.
// - Supply counts as failed only when both sources are lost.
// - Relay closed in correct operation, open on error or power loss.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rssi_top
    import rssi_pkg::*;
#(
    parameter logic [FLASH_W-1:0] FLASH_HALF = FLASH_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic frame_done,
    input wire logic frame_token,
    input wire logic rate_valid,
    input wire logic partner_ok,
    input wire logic slot_known,
    input wire logic slot_short,
    input wire logic supply_a_ok,
    input wire logic supply_b_ok,
    input wire logic supply_miswire,
    input wire logic dev_defect,
    output logic [LIMIT_W-1:0] highest_station_limit,
    output logic led_green,
    output logic led_red,
    output logic relay_closed,
    output logic irq
);

    logic [3:0] pins_s;
    logic sup_a, sup_b, sup_fault;
    logic wr_en, wr_err, rd_en, rd_err;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
    logic [INT_W-1:0] int_stat_r, int_stat_nxt, int_en_r, int_en_nxt;
    logic [INT_W-1:0] int_clr, events;
    logic rate_det_r, rate_det_nxt, rate_hit;
    logic ring_mismatch, alt_cond;
    rssi_led_t state_r, state_nxt;
    logic [FLASH_W-1:0] flash_cnt_r, flash_cnt_nxt;
    logic phase_r, phase_nxt, flash_tick;
    logic green_r, green_nxt, red_r, red_nxt, relay_r, relay_nxt;

    // Merge byte lanes of a write into a stored word.
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Supply and defect lines come from outside the clock domain.
    rssi_sync #(
        .W(4)
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({dev_defect, supply_miswire, supply_b_ok, supply_a_ok}),
        .sync_out(pins_s)
    );

    rssi_axil u_axil (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // A dead supply needs both sources gone; one live input is enough.
    assign sup_a = pins_s[0];
    assign sup_b = pins_s[1];
    assign sup_fault = (!sup_a && !sup_b) || pins_s[2] || pins_s[3];

    // Only a data frame at a valid rate from a sending partner proves the rate,
    // since a lone station passing tokens to itself must not lock it.
    assign rate_hit = frame_done && !frame_token && rate_valid && partner_ok;
    assign ring_mismatch = ctrl_r[CTRL_RING2_BIT] ^ ctrl_r[CTRL_RING3_BIT];
    assign alt_cond = !slot_known || slot_short || ring_mismatch;
    assign highest_station_limit = ctrl_r[CTRL_LIMIT_LSB +: LIMIT_W];
    assign flash_tick = (flash_cnt_r == FLASH_HALF - 1'b1);

    // Indicator state, rate latch, flash divider and output drive.
    always_comb begin
        rate_det_nxt = rate_det_r || rate_hit;
        if (sup_fault) begin
            state_nxt = ST_DARK;
        end else if (!rate_det_r) begin
            state_nxt = ST_RED;
        end else if (alt_cond) begin
            state_nxt = ST_ALT;
        end else begin
            state_nxt = ST_GREEN;
        end
        flash_cnt_nxt = flash_tick ? '0 : flash_cnt_r + 1'b1;
        phase_nxt = flash_tick ? !phase_r : phase_r;
        case (state_nxt)
            ST_DARK: begin
                green_nxt = 1'b0;
                red_nxt = 1'b0;
            end
            ST_RED: begin
                green_nxt = 1'b0;
                red_nxt = phase_nxt;
            end
            ST_ALT: begin
                green_nxt = !phase_nxt;
                red_nxt = phase_nxt;
            end
            default: begin
                green_nxt = 1'b1;
                red_nxt = 1'b0;
            end
        endcase
        relay_nxt = !sup_fault;
    end

    // The relay resets open, matching a repeater without power.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_det_r <= 1'b0;
            state_r <= ST_DARK;
            flash_cnt_r <= '0;
            phase_r <= 1'b0;
            green_r <= 1'b0;
            red_r <= 1'b0;
            relay_r <= 1'b0;
        end else begin
            rate_det_r <= rate_det_nxt;
            state_r <= state_nxt;
            flash_cnt_r <= flash_cnt_nxt;
            phase_r <= phase_nxt;
            green_r <= green_nxt;
            red_r <= red_nxt;
            relay_r <= relay_nxt;
        end
    end

    assign led_green = green_r;
    assign led_red = red_r;
    assign relay_closed = relay_r;

    // Events: rate locked, relay opened, alternating entered.
    always_comb begin
        events = '0;
        events[EV_RATE_BIT] = rate_det_nxt && !rate_det_r;
        events[EV_FAULT_BIT] = relay_r && !relay_nxt;
        events[EV_ALT_BIT] = (state_nxt == ST_ALT) && (state_r != ST_ALT);
    end

    // Register writes; a new event wins over a clear in the same cycle.
    always_comb begin
        ctrl_nxt = ctrl_r;
        int_en_nxt = int_en_r;
        int_clr = '0;
        wr_err = 1'b0;
        if (!wr_en) begin
            wr_err = 1'b0;
        end else if (wr_addr == OFS_CTRL) begin
            ctrl_nxt = lane_merge(ctrl_r, wr_data, wr_strb) & CTRL_MASK;
        end else if (wr_addr == OFS_INT_EN) begin
            int_en_nxt = INT_W'(lane_merge(DATA_W'(int_en_r), wr_data, wr_strb));
        end else if (wr_addr == OFS_INT_CLR) begin
            int_clr = INT_W'(lane_merge('0, wr_data, wr_strb));
        end else if (wr_addr == OFS_STATUS || wr_addr == OFS_INT_STAT) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
        int_stat_nxt = (int_stat_r & ~int_clr) | events;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RST;
            int_en_r <= INT_RST;
            int_stat_r <= INT_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            int_en_r <= int_en_nxt;
            int_stat_r <= int_stat_nxt;
        end
    end

    assign irq = |(int_stat_r & int_en_r);

    // Read multiplexer; the clear register reads as zero.
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (!rd_en) begin
            rd_err = 1'b0;
        end else if (rd_addr == OFS_CTRL) begin
            rd_data = ctrl_r;
        end else if (rd_addr == OFS_STATUS) begin
            rd_data[STAT_STATE_LSB +: 2] = state_r;
            rd_data[STAT_RATE_BIT] = rate_det_r;
            rd_data[STAT_RELAY_BIT] = relay_r;
            rd_data[STAT_SUPA_BIT] = sup_a;
            rd_data[STAT_SUPB_BIT] = sup_b;
        end else if (rd_addr == OFS_INT_STAT) begin
            rd_data[INT_W-1:0] = int_stat_r;
        end else if (rd_addr == OFS_INT_EN) begin
            rd_data[INT_W-1:0] = int_en_r;
        end else if (rd_addr == OFS_INT_CLR) begin
            rd_err = 1'b0;
        end else begin
            rd_err = 1'b1;
        end
    end

    chk_green_steady: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_r == ST_GREEN |-> led_green && !led_red && relay_closed)
        else $error("green state without steady green and closed relay");

    chk_rate_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        rate_det_r |=> rate_det_r)
        else $error("detected rate was forgotten");

    chk_red_flash: assert property (@(posedge core_clk) disable iff (!rst_b)
        !rate_det_r && !sup_fault |=> state_r == ST_RED && !led_green && relay_closed)
        else $error("undetected rate did not give red flashing");

    chk_token_only: assert property (@(posedge core_clk) disable iff (!rst_b)
        !rate_det_r && (frame_token || !partner_ok || !rate_valid) |=> !rate_det_r)
        else $error("rate locked without a valid data frame");

    chk_rate_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
        frame_done && !frame_token && rate_valid && partner_ok
        |=> rate_det_r ##1 rate_det_r)
        else $error("data frame did not lock the rate");

    chk_alt_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
        rate_det_r && !sup_fault && (ring_mismatch || !slot_known || slot_short)
        |=> state_r == ST_ALT && relay_closed)
        else $error("alternating state missed");

    chk_alt_toggle: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_r == ST_ALT && $past(state_r) == ST_ALT && $past(flash_tick)
        |-> led_red != $past(led_red) && led_red != led_green)
        else $error("alternating indicator did not swap");

    chk_dark_fault: assert property (@(posedge core_clk) disable iff (!rst_b)
        sup_fault |=> !led_green && !led_red && !relay_closed)
        else $error("supply fault did not darken and open relay");

    chk_one_supply: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sup_a ^ sup_b) && !pins_s[2] && !pins_s[3] |=> relay_closed [*1])
        else $error("one live supply treated as total failure");

    chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        events[EV_RATE_BIT] && int_en_r[EV_RATE_BIT] && !wr_en |=> irq)
        else $error("enabled event did not raise the interrupt");

endmodule // rssi_top

// ---- include/rssi_pkg.sv ----
// Package of constants and types for the repeater system status indicator.
package rssi_pkg;

    // Core clock rate and flash timing.
    localparam int CLK_KHZ = 200000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_W = 26;
    localparam logic [FLASH_W-1:0] FLASH_HALF_CYC =
        FLASH_W'(FLASH_HALF_MS * (CLK_KHZ / 1000) * 1000);

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INT_CLR = 8'h10;

    // Control register fields and reset value.
    localparam int CTRL_RING2_BIT = 0;
    localparam int CTRL_RING3_BIT = 1;
    localparam int CTRL_LIMIT_LSB = 8;
    localparam int LIMIT_W = 8;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h00007E00;
    localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000FF03;

    // Status register fields.
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_RATE_BIT = 2;
    localparam int STAT_RELAY_BIT = 3;
    localparam int STAT_SUPA_BIT = 4;
    localparam int STAT_SUPB_BIT = 5;

    // Interrupt event bits.
    localparam int INT_W = 3;
    localparam int EV_RATE_BIT = 0;
    localparam int EV_FAULT_BIT = 1;
    localparam int EV_ALT_BIT = 2;
    localparam logic [INT_W-1:0] INT_RST = 3'h0;

    // System indicator states, in order of rising priority reversed.
    typedef enum logic [1:0] {
        ST_DARK = 2'b00,
        ST_RED = 2'b01,
        ST_ALT = 2'b10,
        ST_GREEN = 2'b11
    } rssi_led_t;

endpackage

// ---- hdl/rssi_sync.sv ----
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module rssi_sync #(
    parameter int W = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // Only the second stage is read outside this module.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule // rssi_sync

// ---- hdl/rssi_axil.sv ----
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ps
module rssi_axil
    import rssi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_err
);

    logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [DATA_W-1:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;

    // Address and data are caught separately, so either may come first.
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign wr_en = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_addr = aw_addr_r;
    assign wr_data = w_data_r;
    assign wr_strb = w_strb_r;
    assign rd_en = s_axi_arvalid && !rvalid_r;
    assign rd_addr = s_axi_araddr;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Next state of both channels; the response holds until taken.
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_hold_nxt = w_hold_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_en) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rd_en) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_data;
            rresp_nxt = rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Channel registers.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_hold_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_hold_r <= w_hold_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

endmodule // rssi_axil

// ---- dv/rssi_panel_model.sv ----
// Front-panel observer standing in for the operator and the fault-contact wiring.
`timescale 1ns/1ps
module rssi_panel_model (
    input wire logic core_clk,
    input wire logic clear,
    input wire logic led_green,
    input wire logic led_red,
    input wire logic relay_closed,
    output int red_cnt,
    output int green_cnt,
    output int open_cnt
);
    // Lit cycles of each lamp and open cycles of the contact, counted since the last clear.
    // Counting over whole flash periods keeps the check blind to where the phase starts.
    always @(posedge core_clk) begin
        if (clear) begin
            red_cnt <= 0;
            green_cnt <= 0;
            open_cnt <= 0;
        end else begin
            red_cnt <= red_cnt + int'(led_red === 1'b1);
            green_cnt <= green_cnt + int'(led_green === 1'b1);
            open_cnt <= open_cnt + int'(relay_closed === 1'b0);
        end
    end
endmodule // rssi_panel_model

// ---- dv/rssi_top_tb_top.sv ----
// Self-checking testbench of the repeater system status indicator.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module rssi_top_tb_top;
    import rssi_pkg::*;
    localparam int FH = 8;
    logic core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic frame_done, frame_token, rate_valid, partner_ok, slot_known, slot_short;
    logic supply_a_ok, supply_b_ok, supply_miswire, dev_defect, panel_clear;
    logic [LIMIT_W-1:0] highest_station_limit;
    logic led_green, led_red, relay_closed, irq;
    int red_cnt, green_cnt, open_cnt;
    int err_count = 0;
    int n_compared = 0;

    rssi_top #(.FLASH_HALF(FLASH_W'(FH))) rssi_top_i (
        .core_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .frame_done, .frame_token, .rate_valid, .partner_ok,
        .slot_known, .slot_short, .supply_a_ok, .supply_b_ok, .supply_miswire, .dev_defect,
        .highest_station_limit, .led_green, .led_red, .relay_closed, .irq
    );

    rssi_panel_model rssi_panel_model_i (
        .core_clk, .clear(panel_clear), .led_green, .led_red, .relay_closed,
        .red_cnt, .green_cnt, .open_cnt
    );

    // Free-running 200 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // The one place where the run ends.
    task automatic test_done;
        begin
            if (err_count == 0 && n_compared > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask

    // Write: address and data offered together, each released at its own handshake.
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          input logic [1:0] er);
        logic aw_hit;
        logic w_hit;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge core_clk);
                aw_hit = s_axi_awvalid && s_axi_awready;
                w_hit = s_axi_wvalid && s_axi_wready;
                if (aw_hit) s_axi_awvalid <= 1'b0;
                if (w_hit) s_axi_wvalid <= 1'b0;
            end while ((s_axi_awvalid && !aw_hit) || (s_axi_wvalid && !w_hit));
            do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
            `CHK(s_axi_bresp, er)
            s_axi_bready <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    // Read: the answer is taken at the edge where rvalid is seen high, then an edge passes.
    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic [1:0] rs);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do @(posedge core_clk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
            d = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    // One finished frame, then time for the lock to reach the indicator.
    task automatic send_frame(input logic tok);
        begin
            frame_token <= tok;
            frame_done <= 1'b1;
            @(posedge core_clk);
            frame_done <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    // Indicator state in the status register, on the contact, and over one flash period.
    task automatic chk_state(input rssi_led_t st);
        begin
            axi_rd(OFS_STATUS, v, r);
            `CHK(v[1:0], st)
            `CHK(v[STAT_RELAY_BIT], st != ST_DARK)
            `CHK(relay_closed, st != ST_DARK)
            panel_clear <= 1'b1;
            @(posedge core_clk);
            panel_clear <= 1'b0;
            repeat (2 * FH) @(posedge core_clk);
            @(negedge core_clk);
            `CHK(red_cnt, (st == ST_RED || st == ST_ALT) ? FH : 0)
            `CHK(green_cnt, (st == ST_GREEN) ? 2 * FH : ((st == ST_ALT) ? FH : 0))
            `CHK(open_cnt, (st == ST_DARK) ? 2 * FH : 0)
            @(posedge core_clk);
        end
    endtask

    // Watchdog sized well above the several hundred cycles that the tests need.
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        test_done;
    end

    initial begin
        rst_b = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        {frame_done, frame_token, slot_short, supply_miswire, dev_defect, panel_clear} = 6'h00;
        {rate_valid, partner_ok, slot_known, supply_a_ok, supply_b_ok} = 5'h1F;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        // Register reset values, an unmapped place, and the interrupt enable.
        axi_rd(OFS_CTRL, v, r);
        `CHK(v, CTRL_RST)
        `CHK(highest_station_limit, 8'h7E)
        axi_rd(8'h20, v, r);
        `CHK(r, RESP_SLVERR)
        axi_wr(8'h20, 32'h00000007, RESP_SLVERR);
        axi_wr(OFS_INT_EN, 32'h00000007, RESP_OKAY);
        chk_state(ST_RED);
        // Frames that must not lock the rate.
        send_frame(1'b1);
        partner_ok <= 1'b0;
        send_frame(1'b0);
        partner_ok <= 1'b1;
        rate_valid <= 1'b0;
        send_frame(1'b0);
        rate_valid <= 1'b1;
        axi_rd(OFS_STATUS, v, r);
        `CHK(v[STAT_RATE_BIT], 1'b0)
        `CHK(irq, 1'b0)
        chk_state(ST_RED);
        // A data frame from a second station locks the rate.
        send_frame(1'b0);
        chk_state(ST_GREEN);
        `CHK(irq, 1'b1)
        axi_wr(OFS_INT_CLR, 32'h00000001, RESP_OKAY);
        `CHK(irq, 1'b0)
        partner_ok <= 1'b0;
        rate_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk_state(ST_GREEN);
        // Each cause of alternating, then back to green.
        for (int i = 0; i < 3; i++) begin
            if (i == 0) slot_known <= 1'b0;
            else if (i == 1) axi_wr(OFS_CTRL, 32'h00007E01, RESP_OKAY);
            else slot_short <= 1'b1;
            repeat (4) @(posedge core_clk);
            chk_state(ST_ALT);
            slot_known <= 1'b1;
            slot_short <= 1'b0;
            axi_wr(OFS_CTRL, 32'h00007E03, RESP_OKAY);
            repeat (4) @(posedge core_clk);
            chk_state(ST_GREEN);
        end
        axi_rd(OFS_INT_STAT, v, r);
        `CHK(v[EV_ALT_BIT], 1'b1)
        axi_wr(OFS_INT_EN, 32'h00000003, RESP_OKAY);
        `CHK(irq, 1'b0)
        axi_wr(OFS_INT_CLR, 32'h00000007, RESP_OKAY);
        axi_wr(OFS_INT_EN, 32'h00000007, RESP_OKAY);
        // Wiring and internal faults darken the lamp and open the contact.
        for (int i = 0; i < 2; i++) begin
            if (i == 0) supply_miswire <= 1'b1;
            else dev_defect <= 1'b1;
            repeat (6) @(posedge core_clk);
            chk_state(ST_DARK);
            supply_miswire <= 1'b0;
            dev_defect <= 1'b0;
            repeat (6) @(posedge core_clk);
            chk_state(ST_GREEN);
        end
        // One lost source is no failure; both lost is, and dark outranks alternating.
        supply_a_ok <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk_state(ST_GREEN);
        axi_wr(OFS_INT_CLR, 32'h00000007, RESP_OKAY);
        supply_b_ok <= 1'b0;
        slot_known <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk_state(ST_DARK);
        axi_rd(OFS_INT_STAT, v, r);
        `CHK(v[EV_FAULT_BIT], 1'b1)
        `CHK(irq, 1'b1)
        // Power returns through reset: red flashing outranks alternating.
        supply_a_ok <= 1'b1;
        supply_b_ok <= 1'b1;
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk_state(ST_RED);
        axi_rd(OFS_INT_STAT, v, r);
        `CHK(v[INT_W-1:0], INT_RST)
        test_done;
    end
endmodule // rssi_top_tb_top
